// File: idsgd_core.sv
// Execute stage for dec-skip-nonzero, branch, increments and OR-literal.
// Assumes instr and file_rdata are the executing word and its operand,
// both presented synchronously each cycle that instr_valid is high.
//
// Operation
// - decode dec_skip_nonzero by 0010 011d
// - f minus one to W or f
// - nonzero result flushes prefetch, two cycles
// - branch loads 13-bit literal into PC
// - upper PC byte copied into holding latch
// - branch always two cycles, same 8K page
// - increment_file 0001 010d, f plus one
// - inc_skip_zero writes result, flags untouched
// - inc_skip_zero zero result flushes prefetch
// - inc_skip_nonzero writes, nonzero result flushes
// - OR literal into W, zero flag only
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ns
module idsgd_core (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  output logic [15:0] pc_q,
  output logic [7:0] wreg_q,
  output logic [3:0] flags_q,
  output logic [7:0] latch_q,
  output logic file_we_q,
  output logic [7:0] file_waddr_q,
  output logic [7:0] file_wdata_q,
  output logic flush_q
);

  ////////////////////////////////////////////////////////////////////////
  // Decode
  idsgd_pkg::idsgd_slot_type slot_q, slot_d;
  logic exec;
  logic is_dsnz, is_inc, is_isz, is_isnz, is_or, is_br;
  logic to_file;
  logic [7:0] faddr, lit, inc_res, dec_res, res;
  logic [12:0] br_lit;
  logic skip;

  // A flushed slot is a no-operation whatever word sits in it
  assign exec = instr_valid && (slot_q == idsgd_pkg::SLOT_EXEC);
  assign is_dsnz = exec && (instr[15:9] == idsgd_pkg::OPC_DEC_SKIP_NZ);
  assign is_inc = exec && (instr[15:9] == idsgd_pkg::OPC_INC_FILE);
  assign is_isz = exec && (instr[15:9] == idsgd_pkg::OPC_INC_SKIP_Z);
  assign is_isnz = exec && (instr[15:9] == idsgd_pkg::OPC_INC_SKIP_NZ);
  assign is_or = exec && (instr[15:8] == idsgd_pkg::OPC_OR_LIT);
  assign is_br = exec && (instr[15:13] == idsgd_pkg::OPC_BRANCH);
  assign to_file = instr[idsgd_pkg::DEST_BIT];
  assign faddr = instr[7:0];
  assign lit = instr[7:0];
  assign br_lit = instr[12:0];

  // Arithmetic on the operand; 8-bit wrap is intended
  assign inc_res = file_rdata + idsgd_pkg::ONE8;
  assign dec_res = file_rdata - idsgd_pkg::ONE8;
  assign res = is_dsnz ? dec_res : inc_res;

  // Skip decision for the conditional forms
  assign skip = (is_dsnz && (dec_res != idsgd_pkg::ZERO8))
    || (is_isz && (inc_res == idsgd_pkg::ZERO8))
    || (is_isnz && (inc_res != idsgd_pkg::ZERO8));

  ////////////////////////////////////////////////////////////////////////
  // Slot sequencing and program counter
  logic [15:0] pc_d;
  logic [7:0] latch_d;

  always_comb begin
    slot_d = idsgd_pkg::SLOT_EXEC;
    pc_d = pc_q;
    if (instr_valid) begin
      pc_d = pc_q + idsgd_pkg::PC_STEP;
    end
    // Branch keeps bits 15:13, so the target stays in the page
    if (is_br) begin
      pc_d = {pc_q[15:13], br_lit};
    end
    // Branch and taken skips both kill the prefetched word
    if (is_br || skip) begin
      slot_d = idsgd_pkg::SLOT_FLUSH;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      slot_q <= idsgd_pkg::SLOT_EXEC;
      pc_q <= idsgd_pkg::PC_RST;
      flush_q <= 1'b0;
    end else begin
      slot_q <= slot_d;
      pc_q <= pc_d;
      flush_q <= (slot_d == idsgd_pkg::SLOT_FLUSH);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Working register, flags, latch and file write port
  logic [7:0] wreg_d;
  logic [3:0] flags_d;
  logic file_we_d;
  logic [7:0] file_waddr_d, file_wdata_d, or_res;
  logic arith;

  assign arith = is_dsnz || is_inc || is_isz || is_isnz;
  assign or_res = wreg_q | lit;

  always_comb begin
    wreg_d = wreg_q;
    flags_d = flags_q;
    latch_d = latch_q;
    file_we_d = 1'b0;
    file_waddr_d = faddr;
    file_wdata_d = res;
    // Software writes first so that the executing instruction wins
    if (reg_wr && (reg_addr == idsgd_pkg::WREG_OFS)) begin
      wreg_d = reg_wdata;
    end
    if (reg_wr && (reg_addr == idsgd_pkg::STATUS_OFS)) begin
      flags_d = reg_wdata[3:0];
    end
    if (reg_wr && (reg_addr == idsgd_pkg::LATCH_OFS)) begin
      latch_d = reg_wdata;
    end
    // Destination select on d
    if (arith && !to_file) begin
      wreg_d = res;
    end
    if (arith && to_file) begin
      file_we_d = 1'b1;
    end
    // Only the plain increment touches flags among the arithmetic forms
    if (is_inc) begin
      flags_d[idsgd_pkg::ST_Z] = (inc_res == idsgd_pkg::ZERO8);
      flags_d[idsgd_pkg::ST_C] = (file_rdata == idsgd_pkg::MAX8);
      flags_d[idsgd_pkg::ST_OV] = (file_rdata == idsgd_pkg::SMAX8);
      flags_d[idsgd_pkg::ST_DC] = (file_rdata[3:0] == idsgd_pkg::NIB_MAX);
    end
    if (is_or) begin
      wreg_d = or_res;
      flags_d[idsgd_pkg::ST_Z] = (or_res == idsgd_pkg::ZERO8);
    end
    // Upper PC byte of the new target goes to the holding latch
    if (is_br) begin
      latch_d = pc_d[15:8];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wreg_q <= idsgd_pkg::WREG_RST;
      flags_q <= idsgd_pkg::FLAGS_RST;
      latch_q <= idsgd_pkg::LATCH_RST;
      file_we_q <= 1'b0;
      file_waddr_q <= idsgd_pkg::ZERO8;
      file_wdata_q <= idsgd_pkg::ZERO8;
    end else begin
      wreg_q <= wreg_d;
      flags_q <= flags_d;
      latch_q <= latch_d;
      file_we_q <= file_we_d;
      file_waddr_q <= file_waddr_d;
      file_wdata_q <= file_wdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read port, data one cycle after the strobe
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = idsgd_pkg::ZERO8;
    if (reg_rd) begin
      unique case (reg_addr)
        idsgd_pkg::LATCH_OFS: rdata_d = latch_q;
        idsgd_pkg::STATUS_OFS: rdata_d = {4'h0, flags_q};
        idsgd_pkg::WREG_OFS: rdata_d = wreg_q;
        default: rdata_d = idsgd_pkg::ZERO8; // Unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= idsgd_pkg::ZERO8;
    end else begin
      reg_rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence seq_flush_then_exec;
    (slot_q == idsgd_pkg::SLOT_FLUSH) ##1 (slot_q == idsgd_pkg::SLOT_EXEC);
  endsequence

  sequence seq_two_cycle;
    flush_q ##0 seq_flush_then_exec;
  endsequence

  AST_DSNZ_DEST: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_dsnz && !to_file |=> wreg_q == $past(file_rdata) - idsgd_pkg::ONE8)
    else $error("dec skip nonzero wrote wrong W");

  AST_DSNZ_SKIP: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_dsnz && (file_rdata != idsgd_pkg::ONE8) |=> seq_two_cycle)
    else $error("dec skip nonzero did not flush");

  AST_DSNZ_NOSKIP: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_dsnz && (file_rdata == idsgd_pkg::ONE8) |=> !flush_q)
    else $error("dec skip nonzero flushed on zero");

  AST_BR_PC: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_br |=> pc_q == {$past(pc_q[15:13]), $past(instr[12:0])})
    else $error("branch target wrong");

  AST_BR_LATCH: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_br |=> latch_q == pc_q[15:8])
    else $error("holding latch not loaded");

  AST_BR_TWO: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_br |=> seq_two_cycle)
    else $error("branch not two cycles");

  AST_INC_FLAGS: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_inc && (file_rdata == idsgd_pkg::MAX8)
    |=> flags_q[idsgd_pkg::ST_C] && flags_q[idsgd_pkg::ST_Z] && !flush_q)
    else $error("increment flags wrong");

  AST_INC_FILE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_inc && to_file |=> file_we_q && file_wdata_q == $past(file_rdata) + idsgd_pkg::ONE8)
    else $error("increment file write wrong");

  AST_ISZ_FLAGS: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_isz && !(reg_wr && reg_addr == idsgd_pkg::STATUS_OFS) |=> $stable(flags_q))
    else $error("inc skip zero changed flags");

  AST_ISZ_SKIP: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_isz |=> flush_q == ($past(file_rdata) == idsgd_pkg::MAX8))
    else $error("inc skip zero skip wrong");

  AST_ISNZ_SKIP: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_isnz |=> flush_q == ($past(file_rdata) != idsgd_pkg::MAX8))
    else $error("inc skip nonzero skip wrong");

  AST_OR_ZERO: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_or |=> wreg_q == ($past(wreg_q) | $past(lit))
      && flags_q[idsgd_pkg::ST_Z] == (wreg_q == idsgd_pkg::ZERO8) && !flush_q)
    else $error("OR literal wrong");

  AST_FLUSH_NOP: assert property (@(posedge clk_sys) disable iff (!reset_n)
    slot_q == idsgd_pkg::SLOT_FLUSH |=> !file_we_q)
    else $error("flushed slot wrote file");

  // Flag, destination and cycle-count checks, worked out apart from the update logic
  AST_DSNZ_FILE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_dsnz && to_file |=> file_we_q && file_waddr_q == $past(faddr)
      && file_wdata_q == $past(file_rdata) - idsgd_pkg::ONE8)
    else $error("dec skip nonzero file write wrong");

  AST_INC_ONE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_inc |=> !flush_q && (slot_q == idsgd_pkg::SLOT_EXEC))
    else $error("increment took a second cycle");

  AST_INC_ARITH: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_inc |=> flags_q[idsgd_pkg::ST_C] == ($past(res) < $past(file_rdata))
      && flags_q[idsgd_pkg::ST_OV] == ($past(res) == ~idsgd_pkg::SMAX8)
      && flags_q[idsgd_pkg::ST_DC] == ($past(res[3:0]) == ~idsgd_pkg::NIB_MAX))
    else $error("increment carry, overflow or digit carry wrong");

  AST_ZERO_FLAG: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_inc |=> flags_q[idsgd_pkg::ST_Z] == ($past(res) == idsgd_pkg::ZERO8))
    else $error("zero flag does not follow the result");

  AST_OR_KEEP: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_or && !(reg_wr && reg_addr == idsgd_pkg::STATUS_OFS)
    |=> $stable(flags_q[idsgd_pkg::ST_C]) && $stable(flags_q[idsgd_pkg::ST_DC])
      && $stable(flags_q[idsgd_pkg::ST_OV]) && !file_we_q)
    else $error("OR literal touched more than W and zero");

  AST_ISNZ_FLAGS: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_isnz && !(reg_wr && reg_addr == idsgd_pkg::STATUS_OFS) |=> $stable(flags_q))
    else $error("inc skip nonzero changed flags");

  AST_ISZ_WREG: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_isz && !to_file |=> wreg_q == $past(file_rdata) + idsgd_pkg::ONE8)
    else $error("inc skip zero wrote wrong W");

  AST_DSNZ_FLAGS: assert property (@(posedge clk_sys) disable iff (!reset_n)
    is_dsnz && !(reg_wr && reg_addr == idsgd_pkg::STATUS_OFS) |=> $stable(flags_q))
    else $error("dec skip nonzero changed flags");

endmodule // idsgd_core

// File: idsgd_pkg.sv
// Constants for the increment/decrement/skip/branch decode slice.
// Assumes one core instruction clock; all users reference idsgd_pkg::name.
package idsgd_pkg;
  // Register port offsets
  localparam logic [7:0] LATCH_OFS = 8'h03;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] WREG_OFS = 8'h0A;
  // Reset values
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [15:0] PC_RST = 16'h0000;
  // Status field positions
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;
  // Opcode fields: upper seven bits carry d in bit 8; OR literal uses the upper eight, branch the upper three
  localparam logic [6:0] OPC_DEC_SKIP_NZ = 7'h13;
  localparam logic [6:0] OPC_INC_FILE = 7'h0A;
  localparam logic [6:0] OPC_INC_SKIP_Z = 7'h0F;
  localparam logic [6:0] OPC_INC_SKIP_NZ = 7'h12;
  localparam logic [7:0] OPC_OR_LIT = 8'hB3;
  localparam logic [2:0] OPC_BRANCH = 3'h6;
  localparam int DEST_BIT = 8;
  // Arithmetic constants
  localparam logic [7:0] ONE8 = 8'h01;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] MAX8 = 8'hFF;
  localparam logic [7:0] SMAX8 = 8'h7F;
  localparam logic [3:0] NIB_MAX = 4'hF;
  localparam logic [15:0] PC_STEP = 16'h0001;
  // Execute slot: normal or discarded prefetch
  typedef enum logic {SLOT_EXEC, SLOT_FLUSH} idsgd_slot_type;
endpackage

// File: testbench.sv
// Self-checking bench for the decode slice: instruction slots and register port.
// Assumes idsgd_pkg and idsgd_core are compiled first; no other model is needed.
`timescale 1ns/1ns
module testbench;
  logic clk_sys = 1'b0;
  logic reset_n;
  logic instr_valid;
  logic [15:0] instr;
  logic [7:0] file_rdata;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata_q;
  logic [15:0] pc_q;
  logic [7:0] wreg_q;
  logic [3:0] flags_q;
  logic [7:0] latch_q;
  logic file_we_q;
  logic [7:0] file_waddr_q;
  logic [7:0] file_wdata_q;
  logic flush_q;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Device under test
  idsgd_core i_idsgd_core (.clk_sys(clk_sys), .reset_n(reset_n), .instr_valid(instr_valid),
    .instr(instr), .file_rdata(file_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .pc_q(pc_q),
    .wreg_q(wreg_q), .flags_q(flags_q), .latch_q(latch_q), .file_we_q(file_we_q),
    .file_waddr_q(file_waddr_q), .file_wdata_q(file_wdata_q), .flush_q(flush_q));

  // 250 MHz core clock
  always #2 clk_sys = ~clk_sys;

  // Hang guard: the sequence needs well under 300 cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches = mismatches + 1;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Valid stays high so consecutive calls give back-to-back slots
  task automatic issue(input logic [15:0] w, input logic [7:0] f);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr <= w;
    file_rdata <= f;
    #1;
  endtask
  task automatic idle();
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_q, exp);
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset_n = 1'b0;
    instr_valid = 1'b0;
    instr = 16'h0000;
    file_rdata = 8'h00;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    #1;
    chk(pc_q, 16'h0000);
    chk(latch_q, 8'h00);
    // Nonzero result: second word lands in the discarded slot
    issue(16'h2705, 8'h03);
    issue(16'h1410, 8'h10);
    chk(file_we_q, 1'b1);
    chk(file_waddr_q, 8'h05);
    chk(file_wdata_q, 8'h02);
    chk(flush_q, 1'b1);
    idle();
    chk(file_we_q, 1'b0);
    chk(wreg_q, 8'h00);
    reg_write(idsgd_pkg::WREG_OFS, 8'h55);
    issue(16'h2601, 8'h01);
    idle();
    chk(wreg_q, 8'h00);
    chk(flush_q, 1'b0);
    done("dec_skip_nonzero");
    issue(16'h1420, 8'h7F);
    issue(16'h1521, 8'hFF);
    chk(wreg_q, 8'h80);
    chk(flags_q, 4'hA);
    chk(flush_q, 1'b0);
    idle();
    chk(file_we_q, 1'b1);
    chk(file_wdata_q, 8'h00);
    chk(flags_q, 4'h7);
    done("increment_file");
    issue(16'h1E30, 8'hFF);
    idle();
    chk(wreg_q, 8'h00);
    chk(flush_q, 1'b1);
    issue(16'h1F31, 8'h05);
    idle();
    chk(file_wdata_q, 8'h06);
    chk(flush_q, 1'b0);
    issue(16'h2540, 8'h05);
    idle();
    chk(file_wdata_q, 8'h06);
    chk(flush_q, 1'b1);
    issue(16'h2440, 8'hFF);
    idle();
    chk(flush_q, 1'b0);
    chk(flags_q, 4'h7);
    done("inc_skip");
    reg_write(idsgd_pkg::STATUS_OFS, 8'h0B);
    issue(16'hB300, 8'h00);
    issue(16'hB350, 8'h00);
    chk(flags_q, 4'hF);
    idle();
    chk(wreg_q, 8'h50);
    chk(flags_q, 4'hB);
    done("or_literal_into_working");
    issue(16'hC123, 8'h00);
    issue(16'h1400, 8'h33);
    chk(pc_q, 16'h0123);
    chk(latch_q, 8'h01);
    chk(flush_q, 1'b1);
    idle();
    chk(wreg_q, 8'h50);
    chk(pc_q, 16'h0124);
    issue(16'hDFFF, 8'h00);
    idle();
    chk(pc_q, 16'h1FFF);
    chk(latch_q, 8'h1F);
    // Unknown word steps pc into the next page, then a branch must keep it
    issue(16'h0000, 8'h00);
    issue(16'hC005, 8'h00);
    chk(pc_q, 16'h2000);
    idle();
    chk(pc_q, 16'h2005);
    chk(latch_q, 8'h20);
    done("unconditional_branch");
    reg_write(idsgd_pkg::LATCH_OFS, 8'h5A);
    reg_read(idsgd_pkg::LATCH_OFS, 8'h5A);
    @(posedge clk_sys);
    #1;
    chk(reg_rdata_q, 8'h00);
    reg_read(8'h7E, 8'h00);
    reg_read(idsgd_pkg::WREG_OFS, 8'h50);
    reg_read(idsgd_pkg::STATUS_OFS, 8'h0B);
    done("register_port");
    finish_test();
  end
endmodule // testbench
